// file: include/uci_pkg.sv
// Purpose: Shared constants and types for one UART channel's interrupt logic
// Assumes: One instance per channel, byte-wide register port with 3-bit offset
// Notes:   Identification codes are the 6-bit source field of the ident register
package uci_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [2:0] ADDR_TX_HOLDING = 3'h0;
    localparam logic [2:0] ADDR_INT_ENABLE = 3'h1;
    localparam logic [2:0] ADDR_INT_IDENT  = 3'h2;

    // ************************************************************
    // Interrupt enable field positions and reset
    // ************************************************************
    localparam int IE_RX_DATA  = 0;
    localparam int IE_TX_EMPTY = 1;
    localparam int IE_LINE     = 2;
    localparam int IE_MODEM    = 3;
    localparam int IE_SLEEP    = 4;
    localparam int IE_XOFF     = 5;
    localparam int IE_RTS      = 6;
    localparam int IE_CTS      = 7;
    localparam logic [7:0] IE_RESET = 8'h00;

    // Line status error bits that can raise the line status source
    localparam int LS_ERR_HI = 4;
    localparam int LS_ERR_LO = 1;

    // ************************************************************
    // Identification codes, bits 5:0, highest priority first
    // ************************************************************
    localparam logic [5:0] ID_LINE    = 6'h06;
    localparam logic [5:0] ID_TIMEOUT = 6'h0c;
    localparam logic [5:0] ID_RX_DATA = 6'h04;
    localparam logic [5:0] ID_TX_RDY  = 6'h02;
    localparam logic [5:0] ID_MODEM   = 6'h00;
    localparam logic [5:0] ID_XOFF    = 6'h10;
    localparam logic [5:0] ID_FLOW    = 6'h20;
    localparam logic [5:0] ID_NONE    = 6'h01;
    localparam int         ID_PEND_N  = 0;
    localparam logic [1:0] ID_FIFO_ON  = 2'h3;
    localparam logic [1:0] ID_FIFO_OFF = 2'h0;
    localparam logic [7:0] ID_RESET    = {ID_FIFO_OFF, ID_NONE};

    // ************************************************************
    // Carriers
    // ************************************************************
    // Register port request from the host
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } uci_bus_s;

    // Status from the surrounding UART logic, all on clk_in
    typedef struct packed {
        logic [7:0] line_status;   // Line status register image
        logic       rx_data_ready; // Receive data available (level)
        logic       rx_timeout;    // Receive time-out (level)
        logic       tx_empty;      // Transmit holding/FIFO empty (level)
        logic       modem_change;  // Any modem status change bit set (level)
        logic       modem_status_read; // Host read of modem status (pulse)
        logic       xoff_match;    // Xoff or special character seen (pulse)
        logic       xoff_release;  // Xon or next character seen (pulse)
        logic       rts_level;     // Current RTS output level
        logic       enh_enable;    // Enhanced function enable, feature reg bit 4
        logic       fifo_enable;   // FIFO enable control
    } uci_src_s;

    // State of one channel, apart from the CTS synchroniser
    typedef struct packed {
        logic [7:0] tx_hold;
        logic       tx_wr;
        logic [7:0] int_enable;
        logic [7:0] int_ident;
        logic [7:0] rdata;
        logic       irq;
        logic       sleep;
        logic       tx_pend;
        logic       xoff_pend;
        logic       cts_pend;
        logic       rts_pend;
        logic       cts_prev;
        logic       rts_prev;
        logic       tx_empty_prev;
    } uci_state_s;

endpackage

// file: hdl/uci_sync3.sv
// Purpose: Three-stage synchroniser for a pin level
// Assumes: Input is asynchronous to clk_in
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/1ps
module uci_sync3 (
    input  wire logic clk_in,   // Core clock
    input  wire logic rst_in,   // Async reset, active high
    input  wire logic pin_in,   // Asynchronous level
    output logic      level_out // Filtered, synchronised level
);

    // ************************************************************
    // Synchroniser chain
    // ************************************************************
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } uci_sync_s;

    uci_sync_s q;
    uci_sync_s next_q;

    // Stage one feeds only stage two, so a metastable sample never fans out
    always_comb begin
        next_q    = q;
        next_q.s1 = pin_in;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (q.s2 == q.s3) begin
            next_q.lvl = q.s3;
        end
    end

    // Reset to low: a pin starting high shows a rising edge once the chain fills after reset
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign level_out = q.lvl;

endmodule

// file: hdl/uci_channel.sv
// Purpose: Interrupt enable, identification and transmit holding port of one UART channel
// Assumes: Host strobes are one cycle, never both at once; status inputs are on clk_in
// Notes:   Instantiate once per channel; instances share nothing
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
module uci_channel (
    input  wire logic              clk_in,       // Core clock, 200 MHz
    input  wire logic              rst_in,       // Master reset, async, active high
    input  wire uci_pkg::uci_bus_s bus_in,       // Host register request
    input  wire uci_pkg::uci_src_s src_in,       // Status from UART logic
    input  wire logic              cts_pin_in,   // CTS pin, asynchronous
    output logic [7:0]             rdata_out,    // Read data, cycle after read strobe
    output logic [7:0]             tx_data_out,  // Transmit holding content
    output logic                   tx_write_out, // One-cycle pulse per holding write
    output logic [7:0]             int_enable_out, // Interrupt enable image
    output logic                   sleep_out,    // Sleep mode request
    output logic                   irq_out       // Channel interrupt, active high
);

    // ************************************************************
    // State
    // ************************************************************
    uci_pkg::uci_state_s q;
    uci_pkg::uci_state_s next_q;

    logic       cts_level;
    logic       enh;
    logic       wr_hold;
    logic       wr_ie;
    logic       rd_ident;
    logic       src_line;
    logic       src_timeout;
    logic       src_rx;
    logic       src_tx;
    logic       src_modem;
    logic       src_xoff;
    logic       src_flow;
    logic [5:0] next_code;
    logic [7:0] next_ident;

    // ************************************************************
    // Pin synchroniser
    // ************************************************************
    // CTS comes from the pin, so it is filtered before any edge is looked for
    uci_sync3 u_cts_sync (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (cts_pin_in),
        .level_out (cts_level)
    );

    // ************************************************************
    // Decode and source gating
    // ************************************************************
    // Address decode of the host strobes
    assign wr_hold  = bus_in.wr && (bus_in.addr == uci_pkg::ADDR_TX_HOLDING);
    assign wr_ie    = bus_in.wr && (bus_in.addr == uci_pkg::ADDR_INT_ENABLE);
    assign rd_ident = bus_in.rd && (bus_in.addr == uci_pkg::ADDR_INT_IDENT);
    assign enh      = src_in.enh_enable;

    // Each source is gated by its enable bit (time-out shares bit 0 with receive data), Xoff and flow also by enh; status itself runs on
    assign src_line    = q.int_enable[uci_pkg::IE_LINE] &&
                         (|src_in.line_status[uci_pkg::LS_ERR_HI:uci_pkg::LS_ERR_LO]);
    assign src_timeout = q.int_enable[uci_pkg::IE_RX_DATA] && src_in.rx_timeout;
    assign src_rx      = q.int_enable[uci_pkg::IE_RX_DATA] && src_in.rx_data_ready;
    assign src_tx      = q.int_enable[uci_pkg::IE_TX_EMPTY] && q.tx_pend;
    assign src_modem   = q.int_enable[uci_pkg::IE_MODEM] && src_in.modem_change;
    assign src_xoff    = q.int_enable[uci_pkg::IE_XOFF] && enh && q.xoff_pend;
    // Flow edges need the enhanced enable as well as their own bit
    assign src_flow    = enh && ((q.int_enable[uci_pkg::IE_CTS] && q.cts_pend) ||
                                 (q.int_enable[uci_pkg::IE_RTS] && q.rts_pend));

    // ************************************************************
    // Priority encoder
    // ************************************************************
    // Seven levels, line status highest, flow-control rise lowest
    always_comb begin
        if (src_line) begin
            next_code = uci_pkg::ID_LINE;
        end else if (src_timeout) begin
            next_code = uci_pkg::ID_TIMEOUT;
        end else if (src_rx) begin
            next_code = uci_pkg::ID_RX_DATA;
        end else if (src_tx) begin
            next_code = uci_pkg::ID_TX_RDY;
        end else if (src_modem) begin
            next_code = uci_pkg::ID_MODEM;
        end else if (src_xoff) begin
            next_code = uci_pkg::ID_XOFF;
        end else if (src_flow) begin
            next_code = uci_pkg::ID_FLOW;
        end else begin
            next_code = uci_pkg::ID_NONE;
        end
    end

    // FIFO status mirrors the enable control in the top two bits
    assign next_ident = {(src_in.fifo_enable ? uci_pkg::ID_FIFO_ON : uci_pkg::ID_FIFO_OFF),
                         next_code};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        next_q          = q;
        next_q.tx_wr    = 1'b0;
        next_q.rdata    = 8'h00;
        next_q.cts_prev = cts_level;
        next_q.rts_prev = src_in.rts_level;
        next_q.tx_empty_prev = src_in.tx_empty;

        // Host write of the transmit holding register hands a byte to the tx path
        if (wr_hold) begin
            next_q.tx_hold = bus_in.wdata;
            next_q.tx_wr   = 1'b1;
        end

        // All eight enable bits are plain storage, each independent
        if (wr_ie) begin
            next_q.int_enable = bus_in.wdata;
        end

        // Sleep only honoured with enhanced functions on
        next_q.sleep = next_q.int_enable[uci_pkg::IE_SLEEP] && enh;

        // Read data: holding register is write-only and reads as zero
        if (bus_in.rd) begin
            unique case (bus_in.addr)
                uci_pkg::ADDR_INT_ENABLE: next_q.rdata = q.int_enable;
                uci_pkg::ADDR_INT_IDENT:  next_q.rdata = q.int_ident;
                default:                  next_q.rdata = 8'h00;
            endcase
        end

        // Transmit empty: cleared by a holding write or an ident read showing ID_TX_RDY,
        // but a fresh empty edge in that same cycle wins over the clear
        if (wr_hold || (rd_ident && q.int_ident[5:0] == uci_pkg::ID_TX_RDY)) begin
            next_q.tx_pend = 1'b0;
        end
        if (src_in.tx_empty && !q.tx_empty_prev) begin
            next_q.tx_pend = 1'b1;
        end
        if (!src_in.tx_empty) begin
            next_q.tx_pend = 1'b0;
        end

        // Xoff/special: cleared by ident read or release character; set wins
        if (rd_ident || src_in.xoff_release) begin
            next_q.xoff_pend = 1'b0;
        end
        if (src_in.xoff_match) begin
            next_q.xoff_pend = 1'b1;
        end

        // Flow rises: cleared by ident or modem status read; set wins
        if (rd_ident || src_in.modem_status_read) begin
            next_q.cts_pend = 1'b0;
            next_q.rts_pend = 1'b0;
        end
        if (cts_level && !q.cts_prev) begin
            next_q.cts_pend = 1'b1;
        end
        if (src_in.rts_level && !q.rts_prev) begin
            next_q.rts_pend = 1'b1;
        end

        // Indication holds still during its own read, resumes the cycle after
        if (!rd_ident) begin
            next_q.int_ident = next_ident;
            next_q.irq       = !next_ident[uci_pkg::ID_PEND_N];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Transmit holding content is deliberately not reset: master reset leaves it as is
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            q.tx_wr         <= 1'b0;
            q.int_enable    <= uci_pkg::IE_RESET;
            q.int_ident     <= uci_pkg::ID_RESET;
            q.rdata         <= 8'h00;
            q.irq           <= 1'b0;
            q.sleep         <= 1'b0;
            q.tx_pend       <= 1'b0;
            q.xoff_pend     <= 1'b0;
            q.cts_pend      <= 1'b0;
            q.rts_pend      <= 1'b0;
            q.cts_prev      <= 1'b0;
            q.rts_prev      <= 1'b0;
            q.tx_empty_prev <= 1'b0;
        end else begin
            q <= next_q;
        end
    end

    // ************************************************************
    // Outputs, all straight from flops
    // ************************************************************
    // One channel per instance keeps the two channels fully apart
    assign rdata_out    = q.rdata;
    assign tx_data_out  = q.tx_hold;
    assign tx_write_out = q.tx_wr;
    assign int_enable_out = q.int_enable;
    assign sleep_out    = q.sleep;
    assign irq_out      = q.irq;

endmodule

// file: dv/uci_chk.sv
// Purpose: Port checker for one channel
// Assumes: Ports as declared by uci_channel
// Notes:   Bound at the foot of this file
`timescale 1ns/1ps
module uci_chk (
    input wire logic              clk_in,       // Core clock
    input wire logic              rst_in,       // Async reset
    input wire uci_pkg::uci_bus_s bus_in,       // Host request
    input wire uci_pkg::uci_src_s src_in,       // Status inputs
    input wire logic              cts_pin_in,   // CTS pin
    input wire logic [7:0]        rdata_out,    // Read data
    input wire logic [7:0]        tx_data_out,  // Holding content
    input wire logic              tx_write_out, // Holding pulse
    input wire logic [7:0]        int_enable_out, // Enable image
    input wire logic              sleep_out,    // Sleep request
    input wire logic              irq_out       // Interrupt
);
    // ************************************************************
    // Decoded strobes
    // ************************************************************
    logic wr_tx, wr_ie, rd_id;
    // Shared by several properties to keep them short
    assign wr_tx = bus_in.wr && bus_in.addr == uci_pkg::ADDR_TX_HOLDING;
    assign wr_ie = bus_in.wr && bus_in.addr == uci_pkg::ADDR_INT_ENABLE;
    assign rd_id = bus_in.rd && bus_in.addr == uci_pkg::ADDR_INT_IDENT;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_TX_PULSE: assert property (wr_tx |=> tx_write_out && tx_data_out == $past(bus_in.wdata))
        else $error("holding write not passed on");
    AST_TX_QUIET: assert property (!wr_tx |=> !tx_write_out)
        else $error("stray holding pulse");
    AST_IE_LOAD: assert property (wr_ie |=> int_enable_out == $past(bus_in.wdata))
        else $error("enable write lost");
    AST_IE_KEEP: assert property (!wr_ie |=> $stable(int_enable_out))
        else $error("enable changed without write");
    AST_IE_RST: assert property ($fell(rst_in) |-> int_enable_out == 8'h00 && !irq_out && !sleep_out)
        else $error("state not cleared by reset");
    AST_SLEEP: assert property (sleep_out == (int_enable_out[4] && $past(src_in.enh_enable)))
        else $error("sleep gating wrong");
    AST_FREEZE: assert property (rd_id |=> $stable(irq_out))
        else $error("ident moved during its read");
    AST_PEND_BIT: assert property (rd_id |=> rdata_out[0] == !$past(irq_out))
        else $error("pending bit disagrees with irq");
    AST_RX_RAISE: assert property (int_enable_out[0] && src_in.rx_data_ready && !rd_id |=> irq_out)
        else $error("enabled source did not raise irq");
    AST_MASKED: assert property ($past(int_enable_out, 2) == 8'h00 && $past(int_enable_out) == 8'h00
                                 |-> !irq_out)
        else $error("irq with all sources masked");
endmodule

bind uci_channel uci_chk uci_chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus_in), .src_in(src_in),
    .cts_pin_in(cts_pin_in), .rdata_out(rdata_out), .tx_data_out(tx_data_out),
    .tx_write_out(tx_write_out), .int_enable_out(int_enable_out), .sleep_out(sleep_out), .irq_out(irq_out)
);

// file: dv/uci_host.sv
// Purpose: Host CPU model on the register port
// Assumes: Strobes one cycle, changed after rising edges
// Notes:   Idle address and data toggle so stale values never match
`timescale 1ns/1ps
module uci_host (
    input  wire logic        clk_in,  // Core clock
    input  wire logic [7:0]  rdata_in, // Read data from channel
    output uci_pkg::uci_bus_s bus_out  // Request to channel
);
    initial bus_out = '0;
    // One-byte write, then the bus is released with inverted values
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask
    // Read: data is taken at the edge after the strobe was sampled
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk_in);
        bus_out <= '{addr: a, wdata: ~bus_out.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        bus_out <= '{addr: ~a, wdata: ~bus_out.wdata, wr: 1'b0, rd: 1'b0};
        @(posedge clk_in);
        d = rdata_in;
    endtask
endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench for one channel
// Assumes: Host model drives the register port
// Notes:   Random stimulus from a fixed seed
`timescale 1ns/1ps
module tb;
    localparam logic [2:0] AT = uci_pkg::ADDR_TX_HOLDING;
    localparam logic [2:0] AE = uci_pkg::ADDR_INT_ENABLE;
    localparam logic [2:0] AI = uci_pkg::ADDR_INT_IDENT;
    logic              clk_in = 1'b0;
    logic              rst_in = 1'b1;
    uci_pkg::uci_bus_s bus;
    uci_pkg::uci_src_s src = '0;
    logic              cts = 1'b0;
    logic [7:0]        rdata, txd, int_en, v, b;
    logic              txw, slp, irq, f;
    int                mismatches = 0;
    int                compares = 0;

    initial forever #2.5 clk_in = ~clk_in;

    uci_host uci_host_i (.clk_in(clk_in), .rdata_in(rdata), .bus_out(bus));
    uci_channel uci_channel_i (
        .clk_in(clk_in), .rst_in(rst_in), .bus_in(bus), .src_in(src), .cts_pin_in(cts),
        .rdata_out(rdata), .tx_data_out(txd), .tx_write_out(txw), .int_enable_out(int_en),
        .sleep_out(slp), .irq_out(irq)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Expected ident for source s; 8 means nothing pending
    function automatic logic [7:0] exp_id(input int s, input logic fe);
        logic [5:0] c[9] = '{uci_pkg::ID_LINE, uci_pkg::ID_TIMEOUT, uci_pkg::ID_RX_DATA, uci_pkg::ID_TX_RDY,
            uci_pkg::ID_MODEM, uci_pkg::ID_XOFF, uci_pkg::ID_FLOW, uci_pkg::ID_FLOW, uci_pkg::ID_NONE};
        return {fe ? uci_pkg::ID_FIFO_ON : uci_pkg::ID_FIFO_OFF, c[s]};
    endfunction
    function automatic logic [7:0] ie_of(input int s);
        int k[8] = '{uci_pkg::IE_LINE, uci_pkg::IE_RX_DATA, uci_pkg::IE_RX_DATA, uci_pkg::IE_TX_EMPTY,
            uci_pkg::IE_MODEM, uci_pkg::IE_XOFF, uci_pkg::IE_RTS, uci_pkg::IE_CTS};
        return 8'h01 << k[s];
    endfunction
    task automatic id_chk(input logic [7:0] e);
        uci_host_i.rd(AI, v);
        chk(v, e);
    endtask
    // Raise one source; pulses last one cycle
    task automatic raise(input int s);
        @(posedge clk_in);
        case (s)
            0: src.line_status <= 8'h02 << 2'($urandom % 4);
            1: src.rx_timeout <= 1'b1;
            2: src.rx_data_ready <= 1'b1;
            3: src.tx_empty <= 1'b1;
            4: src.modem_change <= 1'b1;
            5: src.xoff_match <= 1'b1;
            6: src.rts_level <= 1'b1;
            default: cts <= 1'b1;
        endcase
        @(posedge clk_in);
        src.xoff_match <= 1'b0;
    endtask
    // Drop all levels and clear latched flags the way the UART would
    task automatic drop;
        @(posedge clk_in);
        src.line_status <= 8'h00;
        {src.rx_data_ready, src.rx_timeout, src.tx_empty, src.modem_change, src.rts_level} <= 5'h00;
        {src.modem_status_read, src.xoff_release} <= 2'h3;
        cts <= 1'b0;
        @(posedge clk_in);
        {src.modem_status_read, src.xoff_release} <= 2'h0;
        repeat (6) @(posedge clk_in);
    endtask
    // Bounded wait for the interrupt; CTS needs its synchroniser delay
    task automatic wait_irq;
        int n = 0;
        while (irq !== 1'b1 && n < 12) begin
            @(posedge clk_in);
            n++;
        end
        chk({7'h00, irq}, 8'h01);
        // A wait that ran out has already counted; stop here rather than cascade
        if (irq !== 1'b1) begin
            tally_and_finish;
        end
    endtask

    initial begin
        #100000;
        mismatches++;
        tally_and_finish;
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        void'($urandom(32'h6ba1));
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        uci_host_i.rd(AE, v);
        chk(v, uci_pkg::IE_RESET);
        id_chk(exp_id(8, 1'b0));
        // Holding byte must survive a reset in mid-run
        b = 8'($urandom);
        uci_host_i.wr(AT, b);
        uci_host_i.wr(AE, 8'hff);
        @(posedge clk_in);
        chk(txd, b);
        rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk(txd, b);
        chk(int_en, 8'h00);
        rst_in <= 1'b0;
        // Refused writes and reads
        uci_host_i.wr(AI, 8'h3c);
        uci_host_i.wr(3'h5, 8'h3c);
        uci_host_i.rd(AE, v);
        chk(v, 8'h00);
        uci_host_i.rd(AT, v);
        chk(v, 8'h00);
        uci_host_i.rd(3'h6, v);
        chk(v, 8'h00);
        repeat (8) begin
            src.enh_enable <= 1'($urandom);
            b = 8'($urandom);
            uci_host_i.wr(AE, b);
            uci_host_i.rd(AE, v);
            chk(v, b);
            chk({7'h00, slp}, {7'h00, b[4] & src.enh_enable});
        end
        // Each source masked, then enabled; sources 5 to 7 also without enhanced functions
        for (int s = 0; s < 8; s++) begin
            f = 1'($urandom);
            src.fifo_enable <= f;
            src.enh_enable <= 1'b1;
            uci_host_i.wr(AE, ~ie_of(s));
            raise(s);
            repeat (6) @(posedge clk_in);
            chk({7'h00, irq}, 8'h00);
            id_chk(exp_id(8, f));
            drop;
            uci_host_i.wr(AE, ie_of(s));
            raise(s);
            wait_irq;
            id_chk(exp_id(s, f));
            if (s == 3) begin
                id_chk(exp_id(8, f));
                drop;
                raise(3);
                uci_host_i.wr(AT, 8'h5a);
                id_chk(exp_id(8, f));
            end
            drop;
            if (s > 4) begin
                src.enh_enable <= 1'b0;
                raise(s);
                repeat (6) @(posedge clk_in);
                id_chk(exp_id(8, f));
                drop;
            end
        end
        // Priority order with several sources pending at once
        src.enh_enable <= 1'b1;
        uci_host_i.wr(AE, 8'hff);
        for (int s = 0; s < 5; s++) raise(s);
        for (int s = 0; s < 5; s++) begin
            id_chk(exp_id(s, f));
            @(posedge clk_in);
            case (s)
                0: src.line_status <= 8'h00;
                1: src.rx_timeout <= 1'b0;
                2: src.rx_data_ready <= 1'b0;
                4: src.modem_change <= 1'b0;
                default: ;
            endcase
            repeat (2) @(posedge clk_in);
        end
        raise(5);
        raise(6);
        id_chk(exp_id(5, f));
        drop;
        // Release character alone clears the Xoff flag; the lower flow rise shows
        raise(6);
        raise(5);
        @(posedge clk_in);
        src.xoff_release <= 1'b1;
        @(posedge clk_in);
        src.xoff_release <= 1'b0;
        id_chk(exp_id(6, f));
        drop;
        id_chk(exp_id(8, f));
        tally_and_finish;
    end
endmodule
